// ---- logic/alu_map.svh ----
// Register offsets, field positions, reset values for the subtract/swap/xor datapath.
// Assumes byte addressing on the Avalon-MM slave, one 32-bit word per register.
`ifndef ALU_MAP_SVH
`define ALU_MAP_SVH

`define ADDR_ACC        5'h00
`define ADDR_STATUS     5'h04
`define ADDR_CMD        5'h08
`define ADDR_FILE_PTR   5'h0C
`define ADDR_FILE_DATA  5'h10
`define ADDR_DIR        5'h14

`define ST_CARRY        0
`define ST_HALF         1
`define ST_ZERO         2
`define ST_BAD          3

`define CMD_OP_LSB      0
`define CMD_OP_MSB      2
`define CMD_DEST        3
`define CMD_F_LSB       4
`define CMD_F_MSB       10
`define CMD_K_LSB       16
`define CMD_K_MSB       23
`define CMD_MASK        32'h00FF07FF

`define DIR_A_SEL       7'h05
`define DIR_B_SEL       7'h06
`define DIR_C_SEL       7'h07

`define ACC_RESET       8'h00
`define DIR_RESET       8'hFF
`define FILE_RESET      8'h00

`endif

// ---- logic/alu_pkg.sv ----
// Types used by the datapath only; its bench writes op codes as plain numbers.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package alu_pkg;
	typedef enum logic [2:0] {
		SUB_ACC_FROM_REG,
		SUB_WITH_BORROW_OP,
		NIBBLE_EXCHANGE_OP,
		DIRECTION_LOAD_OP,
		XOR_LITERAL_OP,
		XOR_REGISTER_OP
	} aluOp_t;
endpackage
`default_nettype wire

// ---- logic/sub_swap_xor_alu_ops.sv ----
// Execution datapath for subtract, subtract-with-borrow, nibble swap, direction load and XOR ops,
// reached by software over an Avalon-MM slave with waitrequest.
// Assumes alu_map.svh and alu_pkg are compiled first; one clock, asynchronous active-high reset.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "alu_map.svh"
module sub_swap_xor_alu_ops #(
	parameter int FILE_DEPTH = 128
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [4:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [3:0]  byteenable,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	output logic      [7:0]  portADirection,
	output logic      [7:0]  portBDirection,
	output logic      [7:0]  portCDirection
);
	import alu_pkg::*;

	// Byte lanes not enabled keep the register's current value
	function automatic logic [31:0] laneMerge(input logic [31:0] oldWord, input logic [31:0] newWord,
		input logic [3:0] be);
		logic [31:0] merged;
		merged = oldWord;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				merged[i*8 +: 8] = newWord[i*8 +: 8];
			end
		end
		return merged;
	endfunction

	logic        ackReg;
	logic        waitReg;
	logic [31:0] readdataReg;
	logic [7:0]  accReg;
	logic        carryReg;
	logic        halfBorrowReg;
	logic        zeroReg;
	logic        badOpReg;
	logic [31:0] cmdReg;
	logic [6:0]  filePtrReg;
	logic [7:0]  portADirReg;
	logic [7:0]  portBDirReg;
	logic [7:0]  portCDirReg;
	logic [7:0]  fileReg [FILE_DEPTH];

	// Bus decode: the access completes on the edge where ackReg is high
	wire         busy       = read | write;
	wire         takeWrite  = write & ackReg;
	wire         selAcc     = address == `ADDR_ACC;
	wire         selStatus  = address == `ADDR_STATUS;
	wire         selCmd     = address == `ADDR_CMD;
	wire         selPtr     = address == `ADDR_FILE_PTR;
	wire         selData    = address == `ADDR_FILE_DATA;
	wire         selDir     = address == `ADDR_DIR;
	wire [31:0]  statusWord = {28'h0000000, badOpReg, zeroReg, halfBorrowReg, carryReg};
	wire [31:0]  dirWord    = {8'h00, portCDirReg, portBDirReg, portADirReg};

	// Read selection: unmapped offsets read as zero
	wire [7:0]   ptrData    = fileReg[filePtrReg];
	wire [31:0]  readMux    = selAcc    ? {24'h000000, accReg} :
	                          selStatus ? statusWord :
	                          selCmd    ? cmdReg :
	                          selPtr    ? {25'h0, filePtrReg} :
	                          selData   ? {24'h000000, ptrData} :
	                          selDir    ? dirWord : 32'h00000000;
	wire [31:0]  mergedWord = laneMerge(readMux, writedata, byteenable);

	// Command fields; a write to the command register executes it at the same edge
	// Ops see the accumulator and file as they stood before the executing edge
	wire         execute    = takeWrite & selCmd;
	wire [31:0]  cmdWord    = mergedWord & `CMD_MASK;
	wire [2:0]   opCode     = cmdWord[`CMD_OP_MSB:`CMD_OP_LSB];
	wire         destToFile = cmdWord[`CMD_DEST];
	wire [6:0]   fAddr      = cmdWord[`CMD_F_MSB:`CMD_F_LSB];
	wire [7:0]   literal    = cmdWord[`CMD_K_MSB:`CMD_K_LSB];
	wire [7:0]   fValue     = fileReg[fAddr];
	wire aluOp_t op         = aluOp_t'(opCode);

	// Nine- and five-bit differences: the top bit is the borrow out of the byte or low nibble
	wire         isBorrowOp = op == SUB_WITH_BORROW_OP;
	wire         borrowIn   = isBorrowOp & ~carryReg;
	wire [8:0]   diffFull   = {1'b0, fValue} - {1'b0, accReg} - {8'h00, borrowIn};
	wire [4:0]   diffLow    = {1'b0, fValue[3:0]} - {1'b0, accReg[3:0]} - {4'h0, borrowIn};

	// Per-op decode: the result and which state the op may change
	logic [7:0]  result;
	logic        updArith;
	logic        updZero;
	logic        writesDest;
	logic        dirLoad;
	logic        illegal;

	always_comb begin
		result     = 8'h00;
		updArith   = 1'b0;
		updZero    = 1'b0;
		writesDest = 1'b0;
		dirLoad    = 1'b0;
		illegal    = 1'b0;
		unique case (op)
			SUB_ACC_FROM_REG, SUB_WITH_BORROW_OP: begin
				result     = diffFull[7:0];
				updArith   = 1'b1;
				updZero    = 1'b1;
				writesDest = 1'b1;
			end
			NIBBLE_EXCHANGE_OP: begin
				result     = {fValue[3:0], fValue[7:4]};
				writesDest = 1'b1;
			end
			DIRECTION_LOAD_OP: begin
				// Operands other than 5, 6 and 7 only raise the sticky error
				dirLoad    = 1'b1;
				illegal    = fAddr != `DIR_A_SEL && fAddr != `DIR_B_SEL && fAddr != `DIR_C_SEL;
			end
			XOR_LITERAL_OP: begin
				result     = accReg ^ literal;
				updZero    = 1'b1;
			end
			XOR_REGISTER_OP: begin
				result     = accReg ^ fValue;
				updZero    = 1'b1;
				writesDest = 1'b1;
			end
			default: begin
				// Op codes 6 and 7 are undefined
				illegal    = 1'b1;
			end
		endcase
	end

	// Destination routing: literal XOR always lands in the accumulator
	wire         toFile     = execute & writesDest & destToFile;
	wire         toAcc      = execute & ((writesDest & ~destToFile) | op == XOR_LITERAL_OP);
	wire         accSwWrite = takeWrite & selAcc;
	wire         stSwWrite  = takeWrite & selStatus;
	wire         dataWrite  = takeWrite & selData;
	wire         fileWe     = toFile | dataWrite;
	wire [6:0]   fileWrAddr = toFile ? fAddr : filePtrReg;
	wire [7:0]   fileWrData = toFile ? result : mergedWord[7:0];
	wire         loadA      = execute & dirLoad & fAddr == `DIR_A_SEL;
	wire         loadB      = execute & dirLoad & fAddr == `DIR_B_SEL;
	wire         loadC      = execute & dirLoad & fAddr == `DIR_C_SEL;

	// Flag next values and the loads that apply them
	wire         carryNext  = ~diffFull[8];
	wire         halfNext   = ~diffLow[4];
	wire         zeroNext   = result == 8'h00;
	wire         badSet     = execute & illegal;
	wire         arithLoad  = execute & updArith;
	wire         zeroLoad   = execute & updZero;

	// Registered handshake: waitrequest drops for exactly one cycle per request
	wire         ackNext    = busy & ~ackReg;
	wire         readTake   = read & ~ackReg;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ackReg  <= 1'b0;
			waitReg <= 1'b1;
		end else begin
			ackReg  <= ackNext;
			waitReg <= ~ackNext;
		end
	end

	// Read data are taken in the request cycle so they stand through the acknowledge cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			readdataReg <= 32'h00000000;
		end else if (readTake) begin
			readdataReg <= readMux;
		end
	end

	// An executing op has priority over a software write to the accumulator
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			accReg <= `ACC_RESET;
		end else if (toAcc) begin
			accReg <= result;
		end else if (accSwWrite) begin
			accReg <= mergedWord[7:0];
		end
	end

	// Flags: an executing op wins over a software status write; error bit set wins over clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			carryReg      <= 1'b0;
			halfBorrowReg <= 1'b0;
		end else if (arithLoad) begin
			carryReg      <= carryNext;
			halfBorrowReg <= halfNext;
		end else if (stSwWrite) begin
			carryReg      <= mergedWord[`ST_CARRY];
			halfBorrowReg <= mergedWord[`ST_HALF];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			zeroReg <= 1'b0;
		end else if (zeroLoad) begin
			zeroReg <= zeroNext;
		end else if (stSwWrite) begin
			zeroReg <= mergedWord[`ST_ZERO];
		end
	end

	// Sticky error: only a software write clears it, and a same-cycle set still wins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			badOpReg <= 1'b0;
		end else if (badSet) begin
			badOpReg <= 1'b1;
		end else if (stSwWrite) begin
			badOpReg <= mergedWord[`ST_BAD];
		end
	end

	// Command readback holds the last executed word, masked to its defined fields
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cmdReg <= 32'h00000000;
		end else if (execute) begin
			cmdReg <= cmdWord;
		end
	end

	// The pointer picks the file entry that the data offset reads and writes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			filePtrReg <= 7'h00;
		end else if (takeWrite & selPtr) begin
			filePtrReg <= mergedWord[6:0];
		end
	end

	// Direction loads take the accumulator as it stood before the executing edge
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			portADirReg <= `DIR_RESET;
		end else if (loadA) begin
			portADirReg <= accReg;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			portBDirReg <= `DIR_RESET;
		end else if (loadB) begin
			portBDirReg <= accReg;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			portCDirReg <= `DIR_RESET;
		end else if (loadC) begin
			portCDirReg <= accReg;
		end
	end

	// Data file: one flip-flop word per address
	for (genvar g = 0; g < FILE_DEPTH; g++) begin : gFile
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				fileReg[g] <= `FILE_RESET;
			end else if (fileWe && fileWrAddr == 7'(g)) begin
				fileReg[g] <= fileWrData;
			end
		end
	end

	// Every output comes straight from a flip-flop
	assign readdata       = readdataReg;
	assign waitrequest    = waitReg;
	assign portADirection = portADirReg;
	assign portBDirection = portBDirReg;
	assign portCDirection = portCDirReg;
endmodule // sub_swap_xor_alu_ops
`default_nettype wire

// ---- sim/sub_swap_xor_alu_ops_props.sv ----
// Checker for the datapath's Avalon-MM slave and direction register pins.
// Assumes alu_map.svh offsets and a bus master that keeps one access at a time.
`timescale 1ns/100ps
`default_nettype none
`include "alu_map.svh"
module sub_swap_xor_alu_ops_props #(
	parameter int FILE_DEPTH = 128
) (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic [4:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic [7:0]  portADirection,
	input wire logic [7:0]  portBDirection,
	input wire logic [7:0]  portCDirection
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence cmdDone;
		write && !waitrequest && address == `ADDR_CMD;
	endsequence
	sequence dirLoad(sel);
		cmdDone ##0 (writedata[2:0] == 3'h3 && writedata[10:4] == sel);
	endsequence
	a_ack_next: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("no acknowledge one cycle after request");
	a_ack_once: assert property (!waitrequest |=> waitrequest)
		else $error("acknowledge longer than one cycle");
	a_dir_cause: assert property ($changed({portCDirection, portBDirection, portADirection}) |->
		$past(write && !waitrequest && address == `ADDR_CMD)) else $error("direction changed without command");
	a_dir_a_sel: assert property (dirLoad(7'h05) |=> $stable(portBDirection) && $stable(portCDirection))
		else $error("load of A touched B or C");
	a_dir_b_sel: assert property (dirLoad(7'h06) |=> $stable(portADirection) && $stable(portCDirection))
		else $error("load of B touched A or C");
	a_dir_c_sel: assert property (dirLoad(7'h07) |=> $stable(portADirection) && $stable(portBDirection))
		else $error("load of C touched A or B");
	a_dir_bad_sel: assert property (dirLoad(7'h04) |=> $stable({portCDirection, portBDirection, portADirection}))
		else $error("bad operand changed a direction");
	a_dir_readback: assert property (read && !waitrequest && address == `ADDR_DIR |->
		readdata == {8'h00, portCDirection, portBDirection, portADirection}) else $error("direction readback wrong");
	a_unmapped_zero: assert property (read && !waitrequest && (address > `ADDR_DIR || address[1:0] != 2'h0)
		|-> readdata == 32'h0) else $error("unmapped read not zero");
endmodule // sub_swap_xor_alu_ops_props
bind sub_swap_xor_alu_ops sub_swap_xor_alu_ops_props #(.FILE_DEPTH(FILE_DEPTH)) i_props (.clk(clk),
	.reset(reset), .address(address), .read(read), .write(write), .byteenable(byteenable),
	.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .portADirection(portADirection),
	.portBDirection(portBDirection), .portCDirection(portCDirection));
`default_nettype wire

// ---- sim/sub_swap_xor_alu_ops_tb_top.sv ----
// Self-checking bench for the datapath: table of operations, then direction, bad and unmapped cases.
// Assumes alu_map.svh offsets and an Avalon-MM slave that answers through waitrequest.
`timescale 1ns/100ps
`default_nettype none
`include "alu_map.svh"
module sub_swap_xor_alu_ops_tb_top;
	typedef struct packed {
		logic [2:0] op;
		logic       d;
		logic [6:0] f;
		logic [7:0] acc, fv;
		logic [2:0] sIn;
		logic [7:0] eAcc, eFile;
		logic [2:0] eSt;
	} row_t;
	logic        clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, waitrequest;
	logic [4:0]  address = 5'h00;
	logic [3:0]  byteenable = 4'hF;
	logic [31:0] writedata = 32'h0, readdata;
	logic [7:0]  portADirection, portBDirection, portCDirection;
	int          errTotal = 0, cmpCount = 0;
	// Literal of the xor rows doubles as the file value
	row_t rows [11] = '{
		'{3'h0, 1'h0, 7'h7F, 8'h01, 8'h10, 3'h0, 8'h0F, 8'h10, 3'h1},
		'{3'h0, 1'h1, 7'h00, 8'h55, 8'h55, 3'h0, 8'h55, 8'h00, 3'h7},
		'{3'h0, 1'h0, 7'h01, 8'h80, 8'h7F, 3'h7, 8'hFF, 8'h7F, 3'h2},
		'{3'h1, 1'h0, 7'h03, 8'h10, 8'h20, 3'h0, 8'h0F, 8'h20, 3'h1},
		'{3'h1, 1'h1, 7'h04, 8'h20, 8'h20, 3'h1, 8'h20, 8'h00, 3'h7},
		'{3'h2, 1'h0, 7'h05, 8'h00, 8'hA5, 3'h5, 8'h5A, 8'hA5, 3'h5},
		'{3'h2, 1'h1, 7'h06, 8'h11, 8'h3C, 3'h2, 8'h11, 8'hC3, 3'h2},
		'{3'h4, 1'h1, 7'h08, 8'hFF, 8'hFF, 3'h3, 8'h00, 8'hFF, 3'h7},
		'{3'h4, 1'h0, 7'h09, 8'hF0, 8'h0F, 3'h7, 8'hFF, 8'h0F, 3'h3},
		'{3'h5, 1'h1, 7'h0A, 8'h0F, 8'h0F, 3'h0, 8'h0F, 8'h00, 3'h4},
		'{3'h5, 1'h0, 7'h0B, 8'h33, 8'h0C, 3'h5, 8'h3F, 8'h0C, 3'h1}};
	sub_swap_xor_alu_ops #(.FILE_DEPTH(128)) i_dut (.clk(clk), .reset(reset), .address(address),
		.read(read), .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .portADirection(portADirection), .portBDirection(portBDirection),
		.portCDirection(portCDirection));
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmpCount, errTotal);
		if (errTotal == 0 && cmpCount > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmpCount++;
		if (got !== exp) begin
			errTotal++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask
	// Holds the request until waitrequest is sampled low, then releases it
	task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		address <= a;
		write <= w;
		read <= !w;
		writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
		@(posedge clk);
		if (n >= 20) begin
			chk(32'h1, 32'h0, "bus timeout");
			conclude();
		end
	endtask
	initial begin
		row_t r;
		logic [31:0] q;
		logic [2:0][7:0] dirs;
		dirs = 24'hFFFFFF;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk({31'h0, waitrequest}, 32'h1, "idle wait");
		chk(readdata, 32'h0, "reset readdata");
		chk(32'({portCDirection, portBDirection, portADirection}), 32'(dirs), "reset dirs");
		bus(`ADDR_ACC, 1'b0, 32'h0, q);
		chk(q, 32'h0, "reset acc");
		$display("reset test done");
		foreach (rows[i]) begin
			r = rows[i];
			bus(`ADDR_ACC, 1'b1, 32'(r.acc), q);
			bus(`ADDR_FILE_PTR, 1'b1, 32'(r.f), q);
			bus(`ADDR_FILE_DATA, 1'b1, 32'(r.fv), q);
			bus(`ADDR_STATUS, 1'b1, 32'(r.sIn), q);
			bus(`ADDR_CMD, 1'b1, {8'h00, r.fv, 5'h00, r.f, r.d, r.op}, q);
			bus(`ADDR_ACC, 1'b0, 32'h0, q);
			chk(q, 32'(r.eAcc), "acc result");
			bus(`ADDR_FILE_DATA, 1'b0, 32'h0, q);
			chk(q, 32'(r.eFile), "file result");
			bus(`ADDR_STATUS, 1'b0, 32'h0, q);
			chk(q, 32'(r.eSt), "flags");
			$display("row %0d done", i);
		end
		bus(`ADDR_STATUS, 1'b1, 32'h5, q);
		for (int s = 5; s < 8; s++) begin
			bus(`ADDR_ACC, 1'b1, 32'(8'h30 + s), q);
			bus(`ADDR_CMD, 1'b1, {21'h0, 7'(s), 4'h3}, q);
			dirs[s - 5] = 8'(8'h30 + s);
			chk(32'({portCDirection, portBDirection, portADirection}), 32'(dirs), "dir pins");
		end
		bus(`ADDR_CMD, 1'b1, {21'h0, 7'h04, 4'h3}, q);
		chk(32'({portCDirection, portBDirection, portADirection}), 32'(dirs), "bad operand");
		bus(`ADDR_STATUS, 1'b0, 32'h0, q);
		chk(q, 32'hD, "flags kept, bad set");
		bus(`ADDR_DIR, 1'b0, 32'h0, q);
		chk(q, 32'(dirs), "dir readback");
		bus(5'h18, 1'b0, 32'h0, q);
		chk(q, 32'h0, "unmapped read");
		$display("direction and unmapped tests done");
		for (int c = 6; c < 8; c++) begin
			bus(`ADDR_STATUS, 1'b1, 32'h2, q);
			bus(`ADDR_CMD, 1'b1, {21'h0, 7'h0B, 1'b1, 3'(c)}, q);
			bus(`ADDR_STATUS, 1'b0, 32'h0, q);
			chk(q, 32'hA, "undefined op flags");
			bus(`ADDR_FILE_DATA, 1'b0, 32'h0, q);
			chk(q, 32'h0C, "undefined op file");
			bus(`ADDR_ACC, 1'b0, 32'h0, q);
			chk(q, 32'h37, "undefined op acc");
		end
		$display("undefined op tests done");
		byteenable <= 4'hE;
		bus(`ADDR_ACC, 1'b1, 32'h000000AA, q);
		byteenable <= 4'hF;
		bus(`ADDR_ACC, 1'b0, 32'h0, q);
		chk(q, 32'h37, "disabled lane kept");
		$display("byte lane test done");
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		chk(32'({portCDirection, portBDirection, portADirection}), 32'h00FFFFFF, "dirs in reset");
		chk({31'h0, waitrequest}, 32'h1, "wait in reset");
		chk(readdata, 32'h0, "readdata in reset");
		reset <= 1'b0;
		@(posedge clk);
		bus(`ADDR_ACC, 1'b0, 32'h0, q);
		chk(q, 32'h0, "acc after reset");
		bus(`ADDR_STATUS, 1'b0, 32'h0, q);
		chk(q, 32'h0, "flags after reset");
		$display("mid-run reset test done");
		conclude();
	end
endmodule // sub_swap_xor_alu_ops_tb_top
`default_nettype wire
